/* File: dv/pad_board_model.sv */
// Purpose: Carrier board at the pads: pad drive, board sources, pulls.
// Assumes: The bench drives board sources of the pads it controls.
// Notes:   A floating pad flips each cycle, so no stale level passes.
`timescale 1ns/10ps
module pad_board_model (
    input  logic        i_mclk,
    input  logic [20:0] i_out, i_oe, i_pu, i_pd, i_ext_en, i_ext_val,
    output logic [20:0] o_pad
);
    logic flip_q = 1'b0; // Level seen on a floating pad.
    always @(posedge i_mclk) flip_q <= ~flip_q;
    // Pad drive wins, then the board source, then the weak pulls.
    assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                 | (~i_oe & ~i_ext_en & (i_pu | (~i_pd & {21{flip_q}})));
endmodule

/* File: dv/pad_gpio_sleep_control_monitor.sv */
// Purpose: Port checks of the pad and GPIO control block.
// Assumes: Default pad class masks.
// Notes:   Bound to the top module after the checker.
`timescale 1ns/10ps
module pad_gpio_monitor (
    input logic        i_mclk, i_rst, i_sleep_req, o_sleep_ack, o_wake,
    input logic [20:0] i_pad_in, i_sf_out, i_sf_oe, o_gpio_in,
    input logic [20:0] o_pad_out, o_pad_oe, o_pad_pu, o_pad_pd, o_pad_ie
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Two quiet samples first, so the sequencer is surely back in run.
    sequence s_req_held;
        !i_sleep_req [*2] ##1 i_sleep_req [*2];
    endsequence
    sequence s_dpd_held;
        o_sleep_ack && $past(o_sleep_ack);
    endsequence
    chk_reset_state: assert property (disable iff (1'b0)
        i_rst |-> o_pad_pu == 21'h018000 && (o_pad_oe | o_pad_pd | o_pad_ie) == 21'h0)
        else $error("bad reset pads");
    chk_enter_lat: assert property (s_req_held |-> ##1 o_sleep_ack)
        else $error("sleep ack late");
    chk_exit_ack: assert property (o_sleep_ack && !i_sleep_req |=> !o_sleep_ack)
        else $error("sleep ack stuck");
    chk_never_sleep: assert property (1'b1 |=> o_pad_out[20:18] == $past(i_sf_out[20:18])
        && o_pad_oe[20:18] == $past(i_sf_oe[20:18])) else $error("awake pad frozen");
    // Pads that never sleep keep their run receivers on.
    chk_sleep_recv: assert property (s_dpd_held |-> o_pad_ie == 21'h1E7FFF)
        else $error("bad sleep receivers");
    chk_sleep_pull: assert property (s_dpd_held |-> ((o_pad_pu | o_pad_pd) & 21'h1E0000) == 0)
        else $error("pull on in sleep");
    chk_wake_dpd: assert property (o_wake |-> $past(o_sleep_ack))
        else $error("wake outside sleep");
    chk_sync_lat: assert property (o_pad_ie[0] [*3] |-> o_gpio_in[0] == $past(i_pad_in[0], 2))
        else $error("bad sync latency");
    chk_cfg_cleared: assert property ($fell(o_sleep_ack) |=> o_pad_oe[16:0] == 17'h0)
        else $error("setup kept over sleep");
endmodule
bind pad_gpio_sleep_control pad_gpio_monitor pad_gpio_monitor_inst (.*);

/* File: dv/tb.sv */
// Purpose: Self-checking bench of the pad and GPIO control block.
// Assumes: Pads 0..14 GPIO, 15,16 chip selects, 17 clock request, 18..20 awake.
// Notes:   Inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module tb;
    import pad_gpio_pkg::*;
    logic i_mclk, i_rst, i_cfg_we, i_slp_we, i_sleep_req, o_sleep_ack, o_wake;
    logic [IDX_W-1:0] i_cfg_idx;
    pad_cfg_s   i_cfg;
    sleep_cfg_s i_slp;
    logic [20:0] i_irq_clr, i_sf_out, i_sf_oe, o_sf_in, o_gpio_in, o_irq_status, i_pad_in;
    logic [20:0] o_pad_out, o_pad_oe, o_pad_pu, o_pad_pd, o_pad_ie, ext_en, ext_val;
    int num_errors = 0;
    int num_checks = 0;
    pad_gpio_sleep_control pad_gpio_sleep_control_inst (.*);
    pad_board_model pad_board_model_inst (.i_mclk(i_mclk), .i_out(o_pad_out), .i_oe(o_pad_oe),
        .i_pu(o_pad_pu), .i_pd(o_pad_pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(i_pad_in));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic ck(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    // Strobes drop a cycle before the next write may raise them again.
    task automatic wr(input logic [4:0] idx, input logic [7:0] c, input logic [5:0] s,
                      input logic [1:0] we);
        i_cfg_idx = idx;
        i_cfg = c;
        i_slp = s;
        {i_cfg_we, i_slp_we} = we;
        cyc(1);
        {i_cfg_we, i_slp_we} = 2'b00;
        cyc(1);
    endtask
    task automatic wait_ack(input logic v);
        for (int n = 0; n < 20 && o_sleep_ack !== v; n++) cyc(1);
        ck(o_sleep_ack === v, "sleep handshake");
    endtask
    task automatic finish_test;
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic t_reset;
        ck(o_pad_pu === 21'h018000 && o_pad_oe === 21'h0 && o_pad_ie === 21'h0, "reset");
        ck(i_pad_in[16:15] === 2'b11, "selects idle");
        i_rst = 1'b0;
        cyc(2);
        ck(o_pad_ie === 21'h1FFFFF && o_pad_oe[16:0] === 17'h0, "run state");
    endtask
    // Last GPIO line, a mid line, and an index past the end that must be ignored.
    task automatic t_gpio;
        wr(5'h0E, 8'h60, 6'h00, 2'b10);
        wr(5'h03, 8'h60, 6'h00, 2'b10);
        wr(5'h15, 8'hFF, 6'h00, 2'b10);
        ck(o_pad_oe[16:0] === 17'h04008 && o_pad_out[16:0] === 17'h04008, "drive");
    endtask
    // Rising edge on pad 0, low level on pad 1, pad 2 handed to its function.
    task automatic t_irq;
        wr(5'h00, 8'h07, 6'h00, 2'b10);
        wr(5'h01, 8'h04, 6'h00, 2'b10);
        wr(5'h02, 8'h84, 6'h00, 2'b10);
        i_sf_oe[2] = 1'b1;
        ext_val[0] = 1'b1;
        cyc(4);
        ck(o_irq_status[2:0] === 3'b011 && o_gpio_in[1:0] === 2'b01, "flags");
        ck(o_pad_oe[2] === 1'b1 && o_pad_out[2] === 1'b0, "function pad");
        ck(o_sf_in[0] === 1'b1, "function input");
        i_irq_clr = 21'h000003;
        cyc(1);
        i_irq_clr = 21'h000000;
        cyc(1);
        ck(o_irq_status[2:0] === 3'b010, "clear");
    endtask
    task automatic t_sleep;
        wr(5'h03, 8'h00, 6'h10, 2'b01);
        wr(5'h04, 8'h00, 6'h00, 2'b01);
        wr(5'h05, 8'h00, 6'h28, 2'b01);
        wr(5'h06, 8'h00, 6'h23, 2'b01);
        i_sf_out[20:18] = 3'b101;
        i_sf_oe[20:18] = 3'b111;
        i_sleep_req = 1'b1;
        wait_ack(1'b1);
        cyc(2);
        ck(o_pad_oe[5:3] === 3'b011 && o_pad_out[4:3] === 2'b01, "static levels");
        ck(o_pad_pu[5] === 1'b1 && o_pad_pu[16:15] === 2'b00, "sleep pulls");
        ck(o_pad_out[20:18] === 3'b101 && o_pad_ie[17:15] === 3'b100, "awake pads");
        ck(o_wake === 1'b0, "early wake");
        ck(o_sf_in[16:15] === 2'b00, "sleep receivers");
        ext_val[6] = 1'b1;
        wr(5'h07, 8'h60, 6'h00, 2'b10);
        cyc(3);
        ck(o_wake === 1'b1, "wake");
        i_sleep_req = 1'b0;
        wait_ack(1'b0);
        cyc(3);
        ck(o_pad_oe[16:0] === 17'h0, "setup cleared");
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        #20000;
        num_errors++;
        finish_test;
    end
    initial begin
        i_rst = 1'b1;
        {i_cfg_we, i_slp_we, i_sleep_req, i_cfg_idx, i_cfg, i_slp} = '0;
        {i_irq_clr, i_sf_out, i_sf_oe, ext_val} = '0;
        ext_en = 21'h007FFF;
        cyc(6);
        t_reset;
        t_gpio;
        t_irq;
        t_sleep;
        finish_test;
    end
endmodule

/* File: verilog/gpio_line_detect.sv */
// Purpose: Synchronise one pad input and detect its level or edge interrupt condition.
// Assumes: Clear arrives as a one-cycle pulse in the system clock domain.
// Notes:   A set in the clear cycle wins, so no event is lost.
`timescale 1ns/10ps
module gpio_line_detect (
    input  logic i_mclk,     // System clock.
    input  logic i_rst,      // Asynchronous reset, active high.
    input  logic i_pad_in,   // Raw pad level.
    input  logic i_ie,       // Input receiver enabled.
    input  logic i_irq_en,   // Detection enabled.
    input  logic i_edge,     // 1 edge, 0 level.
    input  logic i_pol,      // 1 high or rising, 0 low or falling.
    input  logic i_clr,      // Software clear pulse.
    output logic o_sync,     // Synchronised level.
    output logic o_status    // Sticky interrupt flag.
);

    logic s1_q;      // First synchroniser stage.
    logic s2_q;      // Second synchroniser stage.
    logic prev_q;    // Previous synchronised level for edges.
    logic stat_q;    // Sticky flag.
    logic hit;       // Detection this cycle.

    // ------------------------------------------------------------------
    // Synchroniser; a disabled receiver reads as low.
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q   <= i_pad_in & i_ie;
            s2_q   <= s1_q;
            prev_q <= s2_q;
        end
    end

    // Level matches polarity, or an edge toward the polarity.
    assign hit = i_irq_en & (s2_q == i_pol) & (~i_edge | (s2_q != prev_q));

    // ------------------------------------------------------------------
    // Sticky flag: set wins over clear.
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stat_q <= 1'b0;
        end else begin
            stat_q <= hit | (stat_q & ~i_clr);
        end
    end

    assign o_sync   = s2_q;
    assign o_status = stat_q;

endmodule

/* File: verilog/pad_drive_sel.sv */
// Purpose: Choose the drive, pull and receiver state of one pad for run or deep sleep.
// Assumes: Class inputs are constants fixed at integration.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/10ps
module pad_drive_sel (
    input  logic                     i_dpd,       // Chip in deep power down.
    input  logic                     i_gpio_cap,  // Pad can act as GPIO.
    input  logic                     i_no_sleep,  // Pad never sleeps.
    input  logic                     i_in_wake,   // Receiver kept as wake source.
    input  logic                     i_in_keep,   // Receiver kept for other use.
    input  logic                     i_pull_cfg,  // Sleep pulls configurable.
    input  logic                     i_dyn_out,   // Output stays dynamic in sleep.
    input  pad_gpio_pkg::pad_cfg_s   i_cfg,       // Run-time setup.
    input  pad_gpio_pkg::sleep_cfg_s i_slp,       // Sleep setup.
    input  logic                     i_sf_out,    // Special-function output.
    input  logic                     i_sf_oe,     // Special-function enable.
    output pad_gpio_pkg::pad_drive_s o_drv        // Selected drive.
);
    import pad_gpio_pkg::*;

    logic use_sf;   // Special function owns the pad.

    // ------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------
    always_comb begin
        use_sf = i_cfg.func_special_function_io | ~i_gpio_cap;
        if (i_dpd && !i_no_sleep) begin
            // Sleep path replaces the function selector entirely.
            if (i_dyn_out) begin
                o_drv.out = i_sf_out;
                o_drv.oe  = i_sf_oe;
            end else begin
                o_drv.out = (i_slp.out_mode == SLP_DRIVE_HIGH);
                o_drv.oe  = (i_slp.out_mode != SLP_TRISTATE);
            end
            o_drv.pu = i_pull_cfg & i_slp.pull_up;
            o_drv.pd = i_pull_cfg & i_slp.pull_dn;
            o_drv.ie = i_in_wake | i_in_keep;
        end else begin
            // Normal operation, and always for pads that never sleep.
            o_drv.out = use_sf ? i_sf_out : i_cfg.out_val;
            o_drv.oe  = use_sf ? i_sf_oe : i_cfg.out_en;
            o_drv.pu  = i_cfg.pull_up;
            o_drv.pd  = i_cfg.pull_dn;
            o_drv.ie  = 1'b1;
        end
    end

endmodule

/* File: verilog/pad_gpio_pkg.sv */
// Purpose: Shared constants, pad classes and carrier types for the pad and GPIO control block.
// Assumes: One system clock; pad classes are fixed at integration time through masks.
// Notes:   Pads 0..14 are the dedicated GPIO lines; pads 15..20 are special-function pads.
//
// Contract
// - Every pad has fixed state during reset.
// - Chip-select pads get weak pull-up in reset.
// - One common deep-power-down entry sequence for pads.
// - Sleep input buffer follows pad class.
// - Sleep output static 0/1/tristate or dynamic.
// - Sleep pulls forced off or configured.
// - Controller and test-port pads never sleep.
// - GPIO is output, input or level/edge interrupt.
// - Fifteen dedicated bidirectional GPIO lines with alternates.
// - Special-function pads selectable as GPIO; only pads 15 and 16 are GPIO capable.
// - Sleep bypasses, then resets, function selectors.
package pad_gpio_pkg;

    // ------------------------------------------------------------------
    // Pad counts and index width
    // ------------------------------------------------------------------
    localparam int NUM_GPIO    = 15;                    // Dedicated GPIO lines.
    localparam int NUM_SF_PADS = 6;                     // Special-function pads.
    localparam int NUM_PADS    = NUM_GPIO + NUM_SF_PADS;
    localparam int IDX_W       = $clog2(NUM_PADS);      // Width of a pad index.

    // ------------------------------------------------------------------
    // Default pad class masks, one bit per pad
    // ------------------------------------------------------------------
    localparam logic [NUM_PADS-1:0] CS_PULLUP_MASK_DEF = 21'h018000; // Chip-select pads.
    localparam logic [NUM_PADS-1:0] IN_WAKE_MASK_DEF   = 21'h007FFF; // Wake-event inputs.
    localparam logic [NUM_PADS-1:0] IN_KEEP_MASK_DEF   = 21'h020000; // Clock request input.
    localparam logic [NUM_PADS-1:0] PULL_CFG_MASK_DEF  = 21'h01FFFF; // Configurable pulls.
    localparam logic [NUM_PADS-1:0] DYN_OUT_MASK_DEF   = 21'h1C0000; // Dynamic in sleep.
    localparam logic [NUM_PADS-1:0] NO_SLEEP_MASK_DEF  = 21'h1C0000; // Controller, test port.
    localparam logic [NUM_PADS-1:0] GPIO_CAP_MASK_DEF  = 21'h01FFFF; // GPIO capable pads.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Static output level held by a sleeping pad.
    typedef enum logic [1:0] {
        SLP_DRIVE_LOW,
        SLP_DRIVE_HIGH,
        SLP_TRISTATE
    } slp_out_e;

    // Run-time function selector and GPIO setup of one pad.
    typedef struct packed {
        logic func_special_function_io;   // 1 routes the special function, 0 the GPIO.
        logic out_en;      // GPIO drives the pad.
        logic out_val;     // GPIO output level.
        logic pull_up;     // Weak pull-up.
        logic pull_dn;     // Weak pull-down.
        logic irq_en;      // Interrupt detection enabled.
        logic irq_edge;    // 1 edge, 0 level.
        logic irq_pol;     // 1 high or rising, 0 low or falling.
    } pad_cfg_s;

    // Deep-sleep setup of one pad, kept across sleep.
    typedef struct packed {
        slp_out_e out_mode;
        logic     pull_up;
        logic     pull_dn;
        logic     wake_en;
        logic     wake_pol;  // Wake level: 1 high, 0 low.
    } sleep_cfg_s;

    // Drive state presented to one pad.
    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
        logic pd;
        logic ie;
    } pad_drive_s;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam pad_cfg_s   PAD_CFG_RST   = '0;
    localparam sleep_cfg_s SLEEP_CFG_RST = '{out_mode: SLP_TRISTATE, pull_up: 1'b0,
                                             pull_dn: 1'b0, wake_en: 1'b0, wake_pol: 1'b0};
    localparam pad_drive_s PAD_DRIVE_RST = '0;

endpackage

/* File: verilog/pad_gpio_sleep_control.sv */
// Purpose: Pad and GPIO control with power-on state, deep sleep sequencing and interrupts.
// Assumes: The power management controller drives a level sleep request; inputs are
//          synchronous to i_mclk except pad levels, which are synchronised here.
// Notes:   Pad outputs lag the selected state by one clock because they are registered.
`timescale 1ns/10ps
module pad_gpio_sleep_control #(
    parameter int                   NUM_PADS       = pad_gpio_pkg::NUM_PADS,
    parameter logic [NUM_PADS-1:0]  CS_PULLUP_MASK = pad_gpio_pkg::CS_PULLUP_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  IN_WAKE_MASK   = pad_gpio_pkg::IN_WAKE_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  IN_KEEP_MASK   = pad_gpio_pkg::IN_KEEP_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  PULL_CFG_MASK  = pad_gpio_pkg::PULL_CFG_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  DYN_OUT_MASK   = pad_gpio_pkg::DYN_OUT_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  NO_SLEEP_MASK  = pad_gpio_pkg::NO_SLEEP_MASK_DEF,
    parameter logic [NUM_PADS-1:0]  GPIO_CAP_MASK  = pad_gpio_pkg::GPIO_CAP_MASK_DEF
) (
    input  logic                           i_mclk,        // System clock, 125 MHz.
    input  logic                           i_rst,         // Power-on reset, active high.
    // Configuration ports.
    input  logic                           i_cfg_we,      // Write run-time setup.
    input  logic                           i_slp_we,      // Write sleep setup.
    input  logic [pad_gpio_pkg::IDX_W-1:0] i_cfg_idx,     // Pad addressed by a write.
    input  pad_gpio_pkg::pad_cfg_s         i_cfg,         // Run-time setup data.
    input  pad_gpio_pkg::sleep_cfg_s       i_slp,         // Sleep setup data.
    input  logic [NUM_PADS-1:0]            i_irq_clr,     // Clear pulses for flags.
    // Power management controller.
    input  logic                           i_sleep_req,   // Level: stay in deep sleep.
    output logic                           o_sleep_ack,   // Sequencer in deep power down; pads switch a cycle later.
    output logic                           o_wake,        // Wake event from a pad.
    // Special-function controllers.
    input  logic [NUM_PADS-1:0]            i_sf_out,      // Function output levels.
    input  logic [NUM_PADS-1:0]            i_sf_oe,       // Function output enables.
    output logic [NUM_PADS-1:0]            o_sf_in,       // Pad levels to functions.
    // GPIO state.
    output logic [NUM_PADS-1:0]            o_gpio_in,     // Synchronised pad levels.
    output logic [NUM_PADS-1:0]            o_irq_status,  // Sticky interrupt flags.
    // Pads toward the carrier board.
    input  logic [NUM_PADS-1:0]            i_pad_in,      // Pad receiver levels.
    output logic [NUM_PADS-1:0]            o_pad_out,     // Driven levels.
    output logic [NUM_PADS-1:0]            o_pad_oe,      // High while driving.
    output logic [NUM_PADS-1:0]            o_pad_pu,      // Weak pull-up enables.
    output logic [NUM_PADS-1:0]            o_pad_pd,      // Weak pull-down enables.
    output logic [NUM_PADS-1:0]            o_pad_ie       // Receiver enables.
);
    import pad_gpio_pkg::*;

    // ------------------------------------------------------------------
    // Sleep sequencer state
    // ------------------------------------------------------------------
    // Run, one entry cycle, deep power down, one exit cycle.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_DPD,
        ST_EXIT
    } slp_state_e;

    slp_state_e state_q;     // Sequencer state.
    slp_state_e state_d;     // Next sequencer state.
    logic       deep_power_down_state;         // Sleep path owns the pads.
    logic       cfg_clear;   // Function selectors held at reset value.
    logic       sleep_ack_q; // Registered acknowledge.
    logic       wake_q;      // Registered wake event.
    logic       wake_d;      // Wake condition this cycle.

    // ------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------
    pad_cfg_s   cfg_q [NUM_PADS];   // Run-time setup per pad.
    sleep_cfg_s slp_q [NUM_PADS];   // Sleep setup per pad.
    pad_drive_s drv_d [NUM_PADS];   // Selected drive per pad.
    pad_drive_s drv_q [NUM_PADS];   // Registered drive per pad.
    logic [NUM_PADS-1:0] sync_in;   // Synchronised pad levels.
    logic [NUM_PADS-1:0] irq_stat;  // Flags from the detectors.
    logic [NUM_PADS-1:0] sf_in_q;   // Registered levels for functions.
    logic                idx_ok;    // Write index is inside the pad range.

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Reset setup of a pad; chip selects keep their pull-up after reset.
    function automatic pad_cfg_s cfg_reset(input int k);
        pad_cfg_s c;
        c         = PAD_CFG_RST;
        c.pull_up = CS_PULLUP_MASK[k];
        return c;
    endfunction

    // True when a pad is affected by the sleep bypass.
    function automatic logic sleeps(input int k);
        return ~NO_SLEEP_MASK[k];
    endfunction

    assign deep_power_down_state       = (state_q == ST_DPD);
    assign cfg_clear = (state_q == ST_DPD) || (state_q == ST_EXIT);
    assign idx_ok    = (i_cfg_idx < IDX_W'(NUM_PADS));

    // ------------------------------------------------------------------
    // Sleep sequencer: one sequence serves every sleeping pad.
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (i_sleep_req) begin
                    state_d = ST_ENTER;
                end
            end
            ST_ENTER: begin
                // Setup is frozen two cycles before the registered pads switch over.
                state_d = i_sleep_req ? ST_DPD : ST_RUN;
            end
            ST_DPD: begin
                if (!i_sleep_req) begin
                    state_d = ST_EXIT;
                end
            end
            ST_EXIT: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Run-time setup: writes only in run, cleared while asleep.
    // ------------------------------------------------------------------
    // A write landing in sleep is dropped on purpose: the selectors are being
    // reset, and software must reprogram them after wake anyway.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_PADS; k++) begin
                cfg_q[k] <= cfg_reset(k);
            end
        end else begin
            for (int k = 0; k < NUM_PADS; k++) begin
                if (cfg_clear && sleeps(k)) begin
                    cfg_q[k] <= cfg_reset(k);
                end else if (i_cfg_we && idx_ok && (state_q == ST_RUN)
                             && (i_cfg_idx == IDX_W'(k))) begin
                    cfg_q[k] <= i_cfg;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Sleep setup: kept across sleep, writable outside deep power down.
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_PADS; k++) begin
                slp_q[k] <= SLEEP_CFG_RST;
            end
        end else begin
            for (int k = 0; k < NUM_PADS; k++) begin
                if (i_slp_we && idx_ok && !deep_power_down_state && (i_cfg_idx == IDX_W'(k))) begin
                    slp_q[k] <= i_slp;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-pad drive selection and input detection
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
        // Class bits are constants, so each instance folds to its own logic.
        pad_drive_sel u_sel (
            .i_dpd      (deep_power_down_state),
            .i_gpio_cap (GPIO_CAP_MASK[g]),
            .i_no_sleep (NO_SLEEP_MASK[g]),
            .i_in_wake  (IN_WAKE_MASK[g]),
            .i_in_keep  (IN_KEEP_MASK[g]),
            .i_pull_cfg (PULL_CFG_MASK[g]),
            .i_dyn_out  (DYN_OUT_MASK[g]),
            .i_cfg      (cfg_q[g]),
            .i_slp      (slp_q[g]),
            .i_sf_out   (i_sf_out[g]),
            .i_sf_oe    (i_sf_oe[g]),
            .o_drv      (drv_d[g])
        );

        // Detection only runs for pads that can be GPIO and are set as GPIO.
        gpio_line_detect u_det (
            .i_mclk   (i_mclk),
            .i_rst    (i_rst),
            .i_pad_in (i_pad_in[g]),
            .i_ie     (drv_q[g].ie),
            .i_irq_en (cfg_q[g].irq_en & ~cfg_q[g].func_special_function_io & GPIO_CAP_MASK[g]),
            .i_edge   (cfg_q[g].irq_edge),
            .i_pol    (cfg_q[g].irq_pol),
            .i_clr    (i_irq_clr[g]),
            .o_sync   (sync_in[g]),
            .o_status (irq_stat[g])
        );
    end

    // ------------------------------------------------------------------
    // Pad drive registers: fixed state while reset is asserted.
    // ------------------------------------------------------------------
    // Registering the drive keeps every pad glitch free when the sleep path
    // takes over, at the cost of one cycle of latency.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_PADS; k++) begin
                drv_q[k]    <= PAD_DRIVE_RST;
                drv_q[k].pu <= CS_PULLUP_MASK[k];
            end
        end else begin
            for (int k = 0; k < NUM_PADS; k++) begin
                drv_q[k] <= drv_d[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // Levels handed to the special-function controllers.
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sf_in_q <= '0;
        end else begin
            for (int k = 0; k < NUM_PADS; k++) begin
                sf_in_q[k] <= i_pad_in[k] & drv_q[k].ie;
            end
        end
    end

    // ------------------------------------------------------------------
    // Wake events: wake-class receivers compared with their wake level.
    // ------------------------------------------------------------------
    always_comb begin
        wake_d = 1'b0;
        for (int k = 0; k < NUM_PADS; k++) begin
            if (IN_WAKE_MASK[k] && slp_q[k].wake_en && (sync_in[k] == slp_q[k].wake_pol)) begin
                wake_d = deep_power_down_state;
            end
        end
    end

    // Acknowledge and wake registers.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sleep_ack_q <= 1'b0;
            wake_q      <= 1'b0;
        end else begin
            sleep_ack_q <= (state_d == ST_DPD);
            wake_q      <= wake_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < NUM_PADS; k++) begin
            o_pad_out[k] = drv_q[k].out;
            o_pad_oe[k]  = drv_q[k].oe;
            o_pad_pu[k]  = drv_q[k].pu;
            o_pad_pd[k]  = drv_q[k].pd;
            o_pad_ie[k]  = drv_q[k].ie;
        end
    end

    assign o_sleep_ack  = sleep_ack_q;
    assign o_wake       = wake_q;
    assign o_sf_in      = sf_in_q;
    assign o_gpio_in    = sync_in;
    assign o_irq_status = irq_stat;

endmodule
